// file: rtl/spl_map.svh
// Named constants of the supervisor pin logic
`ifndef SPL_MAP_SVH
`define SPL_MAP_SVH
// Crystal time base
`define SPL_XTAL_HZ 32768
// Power-up hold and reset pulse length
`define SPL_HOLD_MS 250
// Hold time in crystal ticks, least time so rounded up
`define SPL_HOLD_TICKS ((`SPL_HOLD_MS * `SPL_XTAL_HZ + 999) / 1000)
// Watchdog period in crystal ticks
`define SPL_WDOG_TICKS 16384
// Pushbutton debounce in crystal ticks
`define SPL_DEB_TICKS 328
// Timer widths
`define SPL_TMR_W 16
// Serial framing
`define SPL_BITS 4'h8
`define SPL_DIR_BIT 7
`define SPL_ADDR_W 7
`define SPL_BYTE_W 8
`define SPL_LAST_BIT 3'h7
`endif

// file: rtl/spl_pkg.sv
// Types shared by the supervisor pin logic
package spl_pkg;
  // Supervisor state
  typedef enum logic [1:0] {
    SPL_OFF = 2'b00,
    SPL_HOLD = 2'b01,
    SPL_RUN = 2'b10,
    SPL_PULSE = 2'b11
  } spl_state_e;
  // Serial phase
  typedef enum logic [1:0] {
    SPL_CMD = 2'b00,
    SPL_WDATA = 2'b01,
    SPL_RDATA = 2'b10,
    SPL_DONE = 2'b11
  } spl_phase_e;
endpackage

// file: rtl/spl_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module spl_sync #(
  parameter int W = 1
) (
  // Clock and control
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  // All state in one record
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } spl_sync_s;

  spl_sync_s st_ff;
  spl_sync_s nxt_st;

  //////////////////////////////////////////////////////////////////////
  // Next state: a change is taken only when stages two and three agree
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  // Register; clock enable freezes everything
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign q_out = st_ff.q;
endmodule
`default_nettype wire

// file: rtl/spl_top.sv
// Supervisor pin logic: serial port, SRAM gating, interrupt, reset supervisor
`timescale 1ns/1ps
`default_nettype none
`include "spl_map.svh"

module spl_top #(
  parameter logic [`SPL_TMR_W-1:0] HOLD_TICKS = `SPL_TMR_W'(`SPL_HOLD_TICKS),
  parameter logic [`SPL_TMR_W-1:0] WDOG_TICKS = `SPL_TMR_W'(`SPL_WDOG_TICKS),
  parameter logic [`SPL_TMR_W-1:0] DEB_TICKS = `SPL_TMR_W'(`SPL_DEB_TICKS)
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Supply comparator and crystal
  input wire logic power_ok,
  input wire logic crystal_in,
  // Serial port
  input wire logic ser_clk,
  input wire logic ser_sel,
  input wire logic ser_data_in,
  output logic ser_data_out,
  output logic ser_data_oe,
  // Register side, same clock domain
  output logic [`SPL_ADDR_W-1:0] reg_addr,
  output logic [`SPL_BYTE_W-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [`SPL_BYTE_W-1:0] reg_rdata,
  // SRAM gating
  input wire logic ram_enable_in_n,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  output logic ram_high_byte_enable_out_n,
  output logic ram_low_byte_enable_out_n,
  // Interrupt, same clock domain
  input wire logic alarm_flag,
  input wire logic alarm_irq_enable,
  output logic int_out,
  // Reset pin, open drain, and watchdog strobe
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic watchdog_strobe_n
);
  // Synchronised pin bundle positions
  localparam int NSYNC = 9;

  // All state of the block
  typedef struct packed {
    spl_pkg::spl_state_e state;
    spl_pkg::spl_phase_e phase;
    logic [`SPL_TMR_W-1:0] tmr; // Hold and pulse timer
    logic [`SPL_TMR_W-1:0] wdog; // Watchdog timer
    logic [`SPL_TMR_W-1:0] deb; // Pushbutton debounce
    logic xtal_q; // Previous crystal level
    logic sclk_q; // Previous serial clock
    logic sel_q; // Previous select
    logic stb_q; // Previous strobe
    logic [3:0] bitcnt; // Bits in current byte
    logic [`SPL_BYTE_W-1:0] shreg; // Serial shift register
    logic rd_load; // Read data due next cycle
    logic [`SPL_ADDR_W-1:0] addr;
    logic [`SPL_BYTE_W-1:0] wdata;
    logic wr;
    logic rd;
    logic sd_o;
    logic sd_oe;
    logic rst_oe;
    logic rst_o;
    logic ceh_n;
    logic cel_n;
    logic int_o;
  } spl_top_s;

  spl_top_s st_ff;
  spl_top_s nxt_st;

  // Synchronised pins
  logic [NSYNC-1:0] pins_raw;
  logic [NSYNC-1:0] pins_s;
  logic s_pwr, s_xtal, s_sclk, s_sel, s_sdi, s_ramen_n, s_ub_n, s_lb_n, s_rst, s_stb_n;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pins_raw = {power_ok, crystal_in, ser_clk, ser_sel, ser_data_in,
                     ram_enable_in_n, upper_byte_enable_n, lower_byte_enable_n, rst_pin_in};

  spl_sync #(.W(NSYNC)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  // Strobe on its own synchroniser; it resets low, so reset never looks like a fall
  spl_sync #(.W(1)) u_sync_stb (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .d_in(watchdog_strobe_n),
    .q_out(s_stb_n)
  );

  assign {s_pwr, s_xtal, s_sclk, s_sel, s_sdi, s_ramen_n, s_ub_n, s_lb_n, s_rst} = pins_s;

  // Edge helper on registered copies
  // Shared by crystal, serial clock, select and strobe edge detection
  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic tick;
    logic run;
    logic sclk_rise;
    logic sclk_fall;
    logic stb_fall;
    tick = 1'b0;
    run = 1'b0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    stb_fall = 1'b0;
    nxt_st = st_ff;
    nxt_st.wr = 1'b0;
    nxt_st.rd = 1'b0;
    nxt_st.rd_load = 1'b0;
    nxt_st.xtal_q = s_xtal;
    nxt_st.sclk_q = s_sclk;
    nxt_st.sel_q = s_sel;
    nxt_st.stb_q = s_stb_n;

    // Crystal edge drives all timing; no crystal, no time
    tick = rose(s_xtal, st_ff.xtal_q);
    // High-to-low strobe edge restarts the watchdog
    stb_fall = rose(st_ff.stb_q, s_stb_n);
    sclk_rise = rose(s_sclk, st_ff.sclk_q);
    sclk_fall = rose(st_ff.sclk_q, s_sclk);

    // Supervisor state machine
    case (st_ff.state)
      spl_pkg::SPL_OFF: begin
        // Supply out of tolerance: wait for it to return
        nxt_st.tmr = '0;
        if (s_pwr) begin
          nxt_st.state = spl_pkg::SPL_HOLD;
        end
      end
      spl_pkg::SPL_HOLD: begin
        // Hold after supply returns; serial, SRAM, button and strobe inputs ignored meanwhile
        if (tick) begin
          nxt_st.tmr = st_ff.tmr + `SPL_TMR_W'(1);
        end
        if (st_ff.tmr >= HOLD_TICKS) begin
          nxt_st.state = spl_pkg::SPL_RUN;
          nxt_st.tmr = '0;
          nxt_st.wdog = '0;
          nxt_st.deb = '0;
        end
      end
      spl_pkg::SPL_RUN: begin
        run = 1'b1;
        // Watchdog: a high-to-low strobe edge restarts the period
        if (stb_fall) begin
          nxt_st.wdog = '0;
        end else if (tick) begin
          nxt_st.wdog = st_ff.wdog + `SPL_TMR_W'(1);
        end
        // Pushbutton: pin must stay low a full debounce
        if (s_rst) begin
          nxt_st.deb = '0;
        end else if (tick) begin
          nxt_st.deb = st_ff.deb + `SPL_TMR_W'(1);
        end
        if (st_ff.wdog >= WDOG_TICKS || st_ff.deb >= DEB_TICKS) begin
          nxt_st.state = spl_pkg::SPL_PULSE;
          nxt_st.tmr = '0;
        end
      end
      spl_pkg::SPL_PULSE: begin
        // Reset pulse of the full hold length
        if (tick) begin
          nxt_st.tmr = st_ff.tmr + `SPL_TMR_W'(1);
        end
        if (st_ff.tmr >= HOLD_TICKS) begin
          // Pin sensing restarts clean, so our own pull is not seen as a button
          nxt_st.state = spl_pkg::SPL_RUN;
          nxt_st.wdog = '0;
          nxt_st.deb = '0;
        end
      end
      default: begin
        nxt_st.state = spl_pkg::SPL_OFF;
      end
    endcase

    // Supply failure overrides every state and transition
    if (!s_pwr) begin
      nxt_st.state = spl_pkg::SPL_OFF;
    end

    // Reset pin: only ever pulled low, released otherwise
    nxt_st.rst_o = 1'b0;
    nxt_st.rst_oe = (nxt_st.state != spl_pkg::SPL_RUN);

    // SRAM gating: blocked until hold done and while supply fails
    // Registered gate costs a few cycles of latency but never glitches an enable
    nxt_st.ceh_n = ~(run && s_pwr && !s_ramen_n && !s_ub_n);
    nxt_st.cel_n = ~(run && s_pwr && !s_ramen_n && !s_lb_n);

    // Interrupt: active high while flag and enable both set
    // Pure gate, no dependence on supply state
    // Caller owns the sticky flag and its clear; no flag is kept here
    nxt_st.int_o = alarm_flag & alarm_irq_enable;

    // Serial port, ignored during hold or with select low
    // Bits beyond one data byte land in the done phase and are dropped
    if (!run || !s_sel) begin
      nxt_st.phase = spl_pkg::SPL_CMD;
      nxt_st.bitcnt = '0;
      nxt_st.sd_oe = 1'b0;
    end else begin
      if (rose(s_sel, st_ff.sel_q)) begin
        // New transfer: first byte is the command
        nxt_st.phase = spl_pkg::SPL_CMD;
        nxt_st.bitcnt = '0;
      end
      // Load read data in the same cycle as the read strobe
      if (st_ff.rd_load) begin
        nxt_st.shreg = reg_rdata;
      end
      case (st_ff.phase)
        spl_pkg::SPL_CMD: begin
          if (sclk_rise) begin
            // LSB first, sampled on rising clock
            nxt_st.shreg = {s_sdi, st_ff.shreg[`SPL_BYTE_W-1:1]};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt == `SPL_BITS - 4'h1) begin
              nxt_st.bitcnt = '0;
              nxt_st.addr = nxt_st.shreg[`SPL_ADDR_W-1:0];
              if (nxt_st.shreg[`SPL_DIR_BIT]) begin
                nxt_st.phase = spl_pkg::SPL_WDATA;
              end else begin
                nxt_st.phase = spl_pkg::SPL_RDATA;
                nxt_st.rd = 1'b1;
                nxt_st.rd_load = 1'b1;
              end
            end
          end
        end
        spl_pkg::SPL_WDATA: begin
          // Data byte follows the command under the same select
          if (sclk_rise) begin
            nxt_st.shreg = {s_sdi, st_ff.shreg[`SPL_BYTE_W-1:1]};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt == `SPL_BITS - 4'h1) begin
              nxt_st.wdata = nxt_st.shreg;
              nxt_st.wr = 1'b1;
              nxt_st.phase = spl_pkg::SPL_DONE;
            end
          end
        end
        spl_pkg::SPL_RDATA: begin
          // Device drives the data pin on falling clock
          if (sclk_fall) begin
            nxt_st.sd_oe = 1'b1;
            nxt_st.sd_o = st_ff.shreg[0];
            nxt_st.shreg = {1'b0, st_ff.shreg[`SPL_BYTE_W-1:1]};
            nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
            if (st_ff.bitcnt[2:0] == `SPL_LAST_BIT) begin
              nxt_st.phase = spl_pkg::SPL_DONE;
            end
          end
        end
        spl_pkg::SPL_DONE: begin
          // Extra clocks ignored; pin released on next falling edge
          if (sclk_fall) begin
            nxt_st.sd_oe = 1'b0;
          end
        end
        default: begin
          nxt_st.phase = spl_pkg::SPL_CMD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; clock enable freezes all state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.state <= spl_pkg::SPL_OFF;
      st_ff.rst_oe <= 1'b1;
      st_ff.ceh_n <= 1'b1;
      st_ff.cel_n <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign ser_data_out = st_ff.sd_o;
  assign ser_data_oe = st_ff.sd_oe;
  assign reg_addr = st_ff.addr;
  assign reg_wdata = st_ff.wdata;
  assign reg_wr = st_ff.wr;
  assign reg_rd = st_ff.rd;
  assign ram_high_byte_enable_out_n = st_ff.ceh_n;
  assign ram_low_byte_enable_out_n = st_ff.cel_n;
  assign int_out = st_ff.int_o;
  // Reset pin value is fixed low; only its enable moves
  assign rst_pin_out = st_ff.rst_o;
  assign rst_pin_oe = st_ff.rst_oe;
endmodule
`default_nettype wire

// file: verification/spl_top_props.sv
// Assertion checker for the supervisor pin logic
`timescale 1ns/1ps
`default_nettype none
module spl_top_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic power_ok,
  input wire logic ser_sel,
  input wire logic ser_data_oe,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic ram_enable_in_n,
  input wire logic upper_byte_enable_n,
  input wire logic lower_byte_enable_n,
  input wire logic ram_high_byte_enable_out_n,
  input wire logic ram_low_byte_enable_out_n,
  input wire logic alarm_flag,
  input wire logic alarm_irq_enable,
  input wire logic int_out,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Supply held low long enough to pass the synchroniser
  sequence s_fail;
    !power_ok [*8];
  endsequence
  // Both register strobes quiet
  sequence s_idle;
    !reg_wr && !reg_rd;
  endsequence
  AST_INT_ON: assert property ((alarm_flag && alarm_irq_enable) [*2] |-> int_out)
    else $error("int_out low with flag and enable set");
  AST_INT_OFF: assert property (!(alarm_flag && alarm_irq_enable) |=> !int_out)
    else $error("int_out high without flag and enable");
  AST_INT_BATTERY: assert property ((!power_ok && alarm_flag && alarm_irq_enable) [*2] |-> int_out)
    else $error("int_out lost during supply fail");
  AST_HIGH_GATE: assert property (upper_byte_enable_n [*8] |-> ram_high_byte_enable_out_n)
    else $error("high byte enable active without upper enable");
  AST_LOW_GATE: assert property (lower_byte_enable_n [*8] |-> ram_low_byte_enable_out_n)
    else $error("low byte enable active without lower enable");
  AST_RAM_OFF: assert property (ram_enable_in_n [*8] |->
    ram_high_byte_enable_out_n && ram_low_byte_enable_out_n)
    else $error("SRAM enabled without RAM enable");
  AST_FAIL_FORCE: assert property (s_fail |->
    ram_high_byte_enable_out_n && ram_low_byte_enable_out_n && rst_pin_oe)
    else $error("supply fail did not block SRAM and hold reset");
  AST_SEL_IDLE: assert property (!ser_sel [*8] |-> !reg_wr && !reg_rd && !ser_data_oe)
    else $error("serial activity without select");
  AST_STROBE_ONE: assert property ((reg_wr || reg_rd) |=> s_idle)
    else $error("register strobe longer than one cycle");
  AST_DIR_EXCL: assert property (reg_rd |-> !reg_wr)
    else $error("read and write strobes together");
  AST_OPEN_DRAIN: assert property (rst_pin_oe |-> !rst_pin_out)
    else $error("reset pin driven high");
endmodule
bind spl_top spl_top_props u_props (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .power_ok(power_ok),
  .ser_sel(ser_sel),
  .ser_data_oe(ser_data_oe),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .ram_enable_in_n(ram_enable_in_n),
  .upper_byte_enable_n(upper_byte_enable_n),
  .lower_byte_enable_n(lower_byte_enable_n),
  .ram_high_byte_enable_out_n(ram_high_byte_enable_out_n),
  .ram_low_byte_enable_out_n(ram_low_byte_enable_out_n),
  .alarm_flag(alarm_flag),
  .alarm_irq_enable(alarm_irq_enable),
  .int_out(int_out),
  .rst_pin_out(rst_pin_out),
  .rst_pin_oe(rst_pin_oe)
);
`default_nettype wire

// file: verification/spl_host_model.sv
// Host processor model driving the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module spl_host_model (
  // Clock and data wire
  input wire logic sys_clk,
  input wire logic ser_data_in,
  // Host driven lines
  output logic ser_clk,
  output logic ser_sel,
  output logic host_d
);
  // Serial clock stands low outside frames
  initial begin
    ser_clk = 1'b0;
    ser_sel = 1'b0;
    host_d = 1'b0;
  end
  // Half a serial period, 40 ns
  task automatic half;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask
  // Command byte then data byte, LSB first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] frame;
    frame = {wd, cmd};
    rd = 8'h00;
    ser_sel = 1'b1;
    for (int i = 0; i < 16; i++) begin
      // Released line toggles so a stale level never reads as data
      host_d = (i < 8 || cmd[7]) ? frame[i] : ~host_d;
      half();
      if (i >= 8) rd[i-8] = ser_data_in;
      ser_clk = 1'b1;
      half();
      ser_clk = 1'b0;
    end
    half();
    ser_sel = 1'b0;
    host_d = ~host_d;
    half();
  endtask
endmodule
`default_nettype wire

// file: verification/spl_top_tb.sv
// Self-checking bench for the supervisor pin logic
`timescale 1ns/1ps
`default_nettype none
module spl_top_tb;
  // Shortened tick counts
  localparam int HOLD = 8;
  localparam int WDOG = 20;
  localparam int DEB = 3;
  logic sys_clk, sys_rst, power_ok, crystal_in, btn;
  logic wd_on = 1'b1;
  logic ram_enable_in_n, upper_byte_enable_n, lower_byte_enable_n;
  logic alarm_flag, alarm_irq_enable, watchdog_strobe_n;
  logic ser_clk, ser_sel, host_d, ser_data_out, ser_data_oe, reg_wr, reg_rd, int_out;
  logic ram_high_byte_enable_out_n, ram_low_byte_enable_out_n, rst_pin_out, rst_pin_oe;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  int n_mismatch = 0;
  int samples_checked = 0;
  int ticks = 0;
  int cyc = 0;
  int n_wr = 0;
  int n_rd = 0;
  integer seed = 39;
  // Register file stand-in
  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    return {a[2:0], a[6:2]} ^ 8'h5a;
  endfunction
  wire logic clk_en = 1'b1;
  wire logic [7:0] reg_rdata = exp_rd(reg_addr);
  wire logic ser_data_in = ser_data_oe ? ser_data_out : host_d;
  wire logic rst_pin_in = !(rst_pin_oe || btn);
  spl_top #(.HOLD_TICKS(16'(HOLD)), .WDOG_TICKS(16'(WDOG)), .DEB_TICKS(16'(DEB))) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .power_ok(power_ok), .crystal_in(crystal_in),
    .ser_clk(ser_clk), .ser_sel(ser_sel), .ser_data_in(ser_data_in),
    .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ram_enable_in_n(ram_enable_in_n), .upper_byte_enable_n(upper_byte_enable_n),
    .lower_byte_enable_n(lower_byte_enable_n),
    .ram_high_byte_enable_out_n(ram_high_byte_enable_out_n),
    .ram_low_byte_enable_out_n(ram_low_byte_enable_out_n),
    .alarm_flag(alarm_flag), .alarm_irq_enable(alarm_irq_enable), .int_out(int_out),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .watchdog_strobe_n(watchdog_strobe_n)
  );
  spl_host_model host (.sys_clk(sys_clk), .ser_data_in(ser_data_in), .ser_clk(ser_clk),
    .ser_sel(ser_sel), .host_d(host_d));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Fast crystal keeps the run short
  initial begin
    crystal_in = 1'b0;
    forever #200 crystal_in = ~crystal_in;
  end
  always @(posedge crystal_in) ticks++;
  // Strobe counts and hang guard
  always @(posedge sys_clk) begin
    n_wr += reg_wr;
    n_rd += reg_rd;
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic in_range(input string nm, input int n, input int lo, input int hi);
    chk(nm, 8'h01, {7'h00, n >= lo && n <= hi});
  endtask
  task automatic wait_oe(input logic v);
    for (int i = 0; i < 6000 && rst_pin_oe !== v; i++) tick(1);
  endtask
  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Host strobes the watchdog every five ticks
  initial begin
    watchdog_strobe_n = 1'b1;
    forever begin
      repeat (5) @(posedge crystal_in);
      if (wd_on) begin
        tick(1);
        watchdog_strobe_n = 1'b0;
        tick(8);
        watchdog_strobe_n = 1'b1;
      end
    end
  end
  initial begin
    int t;
    logic [7:0] a, d, r;
    logic [2:0] v;
    {sys_rst, power_ok, btn, alarm_flag, alarm_irq_enable} = 5'h10;
    {ram_enable_in_n, upper_byte_enable_n, lower_byte_enable_n} = 3'h7;
    tick(4);
    chk("rst_oe", 8'h01, {7'h00, rst_pin_oe});
    sys_rst = 0;
    {ram_enable_in_n, upper_byte_enable_n, lower_byte_enable_n} = 3'h0;
    tick(10);
    t = ticks;
    power_ok = 1;
    tick(200);
    chk("ram_hi", 8'h01, {7'h00, ram_high_byte_enable_out_n});
    wait_oe(0);
    in_range("hold", ticks - t, HOLD, HOLD + 1);
    $display("test power_up done");
    for (int i = 0; i < 24; i++) begin
      v = (i < 8) ? i[2:0] : 3'($random(seed));
      {ram_enable_in_n, upper_byte_enable_n, lower_byte_enable_n} = v;
      tick(10);
      chk("ram_hi", {7'h00, v[2] | v[1]}, {7'h00, ram_high_byte_enable_out_n});
      chk("ram_lo", {7'h00, v[2] | v[0]}, {7'h00, ram_low_byte_enable_out_n});
      {alarm_flag, alarm_irq_enable} = 2'($random(seed));
      tick(2);
      chk("int", {7'h00, alarm_flag & alarm_irq_enable}, {7'h00, int_out});
    end
    $display("test sram_int done");
    // Reads on even passes, writes on odd; both address extremes first
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? {1'b0, {7{i[0]}}} : 8'($random(seed)) & 8'h7f;
      d = 8'($random(seed));
      host.xfer({i[0], a[6:0]}, d, r);
      tick(4);
      chk("addr", a, {1'b0, reg_addr});
      if (i[0]) chk("wdata", d, reg_wdata);
      else chk("rdata", exp_rd(a[6:0]), r);
    end
    chk("n_wr", 8'h04, n_wr[7:0]);
    chk("n_rd", 8'h04, n_rd[7:0]);
    $display("test serial done");
    {ram_enable_in_n, upper_byte_enable_n, lower_byte_enable_n} = 3'h0;
    {alarm_flag, alarm_irq_enable, power_ok} = 3'h6;
    tick(12);
    chk("ram_lo", 8'h01, {7'h00, ram_low_byte_enable_out_n});
    chk("rst_oe", 8'h01, {7'h00, rst_pin_oe});
    chk("int", 8'h01, {7'h00, int_out});
    t = ticks;
    power_ok = 1;
    wait_oe(0);
    in_range("rehold", ticks - t, HOLD, HOLD + 1);
    $display("test supply_fail done");
    tick(2000);
    chk("rst_oe", 8'h00, {7'h00, rst_pin_oe});
    @(negedge watchdog_strobe_n);
    wd_on = 0;
    t = ticks;
    wait_oe(1);
    in_range("wdog", ticks - t, WDOG - 1, WDOG + 1);
    wd_on = 1;
    t = ticks;
    wait_oe(0);
    in_range("pulse", ticks - t, HOLD - 1, HOLD + 1);
    $display("test watchdog done");
    // A press shorter than the debounce is ignored
    btn = 1;
    tick(40);
    btn = 0;
    tick(400);
    chk("rst_oe", 8'h00, {7'h00, rst_pin_oe});
    btn = 1;
    t = ticks;
    wait_oe(1);
    btn = 0;
    in_range("deb", ticks - t, DEB - 1, DEB + 1);
    t = ticks;
    wait_oe(0);
    in_range("btn_pulse", ticks - t, HOLD - 1, HOLD + 1);
    $display("test button done");
    end_sim();
  end
endmodule
`default_nettype wire
